/* hdl/vdo_regs.svh */
// Purpose: Register offsets, field positions and reset values of the decoder status bank.
// Assumes: Eight-bit registers reached by an eight-bit subaddress on the two-wire port.
// Notes: Definitions only.
`ifndef VDO_REGS_SVH
`define VDO_REGS_SVH
`define VDO_OFS_NEG_MUX 8'h60
`define VDO_OFS_HS_SRC 8'h6A
`define VDO_OFS_FLD_SRC 8'h6B
`define VDO_OFS_PIX_CFG 8'h8F
`define VDO_OFS_CAP1 8'h99
`define VDO_OFS_CAP2 8'h9A
`define VDO_OFS_LB_TOP 8'h9B
`define VDO_OFS_LB_MID 8'h9C
`define VDO_OFS_LB_BOT 8'h9D
`define VDO_OFS_CRC_EN 8'hB2
`define VDO_OFS_MUX_CTL 8'hC4
`define VDO_RST_NEG_MUX 8'h10
`define VDO_RST_HS_SRC 8'h00
`define VDO_RST_FLD_SRC 8'h10
`define VDO_RST_PIX_CFG 8'h00
`define VDO_RST_CRC_EN 8'h18
`define VDO_RST_MUX_CTL 8'h00
`define VDO_BIT_MAN_MUX 7
`define VDO_BIT_CRC_EN 2
`define VDO_NEG_MUX_MAX 4'h8
`define VDO_PIX_FULL 3'h0
`define VDO_PIX_HALF 3'h5
`define VDO_UNMAPPED_RD 8'h00
`endif

/* hdl/vdo_pkg.sv */
// Purpose: Types shared by the decoder status bank.
// Assumes: Nothing beyond the register header.
// Notes: Sync source codes are shared by both sync output pins.
package vdo_pkg;
	typedef enum logic [2:0] {
		SRC_HSYNC = 3'b000,
		SRC_VSYNC = 3'b001,
		SRC_FIELD = 3'b010,
		SRC_DE = 3'b011,
		SRC_SC_LOCK = 3'b100
	} vdo_sync_src_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_SUB = 4'b0011,
		ST_SUB_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RACK = 4'b1000
	} vdo_ser_state_t;
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic field;
		logic de;
		logic subcarrier_lock_info;
	} vdo_sync_t;
	typedef struct packed {
		logic valid;
		logic [7:0] byte_first;
		logic [7:0] byte_second;
	} vdo_caption_t;
	typedef struct packed {
		logic field_start;
		logic field_end;
		logic line_done;
		logic line_black;
		logic in_middle;
		logic subtitles;
	} vdo_lbox_t;
endpackage

/* hdl/vdo_output_status.sv */
// Purpose: Output routing, caption, letterbox and checksum status registers of a video decoder.
// Assumes: Serial clock and data pins are synchronous to clk and slow against it.
// Notes: Registers are reached over the two-wire serial port with auto-incrementing subaddress.
`timescale 1ns/1ps
`include "vdo_regs.svh"
module vdo_output_status #(
	parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary bus address.
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o_reg,
	output logic sda_oe_n_reg,
	input wire vdo_pkg::vdo_sync_t sync_in,
	input wire logic pix_clk_full,
	input wire logic pix_clk_half,
	input wire vdo_pkg::vdo_caption_t caption_in,
	input wire vdo_pkg::vdo_lbox_t lbox_in,
	input wire logic cm_rx_valid,
	input wire logic cm_crc_ok,
	output logic manual_mux_enable_reg,
	output logic [3:0] analog_input_n_reg,
	output logic hsync_pin_reg,
	output logic field_pin_reg,
	output logic line_locked_pixel_clock_reg,
	output logic cm_valid_reg
);
	logic [7:0] neg_mux_reg;
	logic [7:0] hs_src_reg;
	logic [7:0] fld_src_reg;
	logic [7:0] pix_clk_cfg_reg;
	logic [7:0] crc_en_reg;
	logic [7:0] mux_ctl_reg;
	logic [7:0] cap1_reg;
	logic [7:0] cap2_reg;
	logic [7:0] lb_top_reg;
	logic [7:0] lb_mid_reg;
	logic [7:0] lb_bot_reg;
	logic [7:0] top_run_reg;
	logic [7:0] mid_run_reg;
	logic [7:0] bot_run_reg;
	logic top_open_reg;
	vdo_pkg::vdo_ser_state_t st_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] sub_reg;
	logic [7:0] tx_reg;
	logic rw_reg;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic wr_stb;

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	function automatic logic pick_src(input logic [2:0] sel, input vdo_pkg::vdo_sync_t s);
		case (vdo_pkg::vdo_sync_src_t'(sel))
			vdo_pkg::SRC_HSYNC: pick_src = s.hsync;
			vdo_pkg::SRC_VSYNC: pick_src = s.vsync;
			vdo_pkg::SRC_FIELD: pick_src = s.field;
			vdo_pkg::SRC_DE: pick_src = s.de;
			vdo_pkg::SRC_SC_LOCK: pick_src = s.subcarrier_lock_info;
			default: pick_src = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] rd_data(input logic [7:0] a);
		case (a)
			`VDO_OFS_NEG_MUX: rd_data = neg_mux_reg;
			`VDO_OFS_HS_SRC: rd_data = hs_src_reg;
			`VDO_OFS_FLD_SRC: rd_data = fld_src_reg;
			`VDO_OFS_PIX_CFG: rd_data = pix_clk_cfg_reg;
			`VDO_OFS_CAP1: rd_data = cap1_reg;
			`VDO_OFS_CAP2: rd_data = cap2_reg;
			`VDO_OFS_LB_TOP: rd_data = lb_top_reg;
			`VDO_OFS_LB_MID: rd_data = lb_mid_reg;
			`VDO_OFS_LB_BOT: rd_data = lb_bot_reg;
			`VDO_OFS_MUX_CTL: rd_data = mux_ctl_reg;
			default: rd_data = `VDO_UNMAPPED_RD;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Two-wire serial slave
	// --------------------------------------------------------------
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
	assign wr_stb = (st_reg == vdo_pkg::ST_WDATA) && scl_fall && (cnt_reg == 4'h8);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= vdo_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			sub_reg <= 8'h00;
			tx_reg <= 8'hFF;
			rw_reg <= 1'b0;
		end
		else if (start_cond)
		begin
			st_reg <= vdo_pkg::ST_ADDR;
			cnt_reg <= 4'h0;
		end
		else if (stop_cond)
			st_reg <= vdo_pkg::ST_IDLE;
		else
		begin
			case (st_reg)
				vdo_pkg::ST_ADDR, vdo_pkg::ST_SUB, vdo_pkg::ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], sda_i};
						cnt_reg <= cnt_reg + 4'h1;
					end
					else if (scl_fall && cnt_reg == 4'h8)
					begin
						cnt_reg <= 4'h0;
						if (st_reg == vdo_pkg::ST_SUB)
						begin
							sub_reg <= shift_reg;
							st_reg <= vdo_pkg::ST_SUB_ACK;
						end
						else if (st_reg == vdo_pkg::ST_WDATA)
						begin
							sub_reg <= sub_reg + 8'h01;
							st_reg <= vdo_pkg::ST_WACK;
						end
						else if (shift_reg[7:1] == DEV_ADDR)
						begin
							rw_reg <= shift_reg[0];
							st_reg <= vdo_pkg::ST_ADDR_ACK;
						end
						else
							st_reg <= vdo_pkg::ST_IDLE;
					end
				end
				vdo_pkg::ST_ADDR_ACK, vdo_pkg::ST_SUB_ACK, vdo_pkg::ST_WACK:
				begin
					if (scl_fall)
					begin
						if (st_reg == vdo_pkg::ST_ADDR_ACK && rw_reg)
						begin
							tx_reg <= rd_data(sub_reg);
							st_reg <= vdo_pkg::ST_RDATA;
						end
						else if (st_reg == vdo_pkg::ST_ADDR_ACK)
							st_reg <= vdo_pkg::ST_SUB;
						else
							st_reg <= vdo_pkg::ST_WDATA;
					end
				end
				vdo_pkg::ST_RDATA:
				begin
					if (scl_fall)
					begin
						tx_reg <= {tx_reg[6:0], 1'b1};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == 4'h7)
						begin
							cnt_reg <= 4'h0;
							tx_reg <= 8'hFF;
							st_reg <= vdo_pkg::ST_RACK;
						end
					end
				end
				vdo_pkg::ST_RACK:
				begin
					if (scl_rise)
						rw_reg <= ~sda_i;
					else if (scl_fall)
					begin
						if (rw_reg)
						begin
							tx_reg <= rd_data(sub_reg + 8'h01);
							sub_reg <= sub_reg + 8'h01;
							st_reg <= vdo_pkg::ST_RDATA;
						end
						else
							st_reg <= vdo_pkg::ST_IDLE;
					end
				end
				default: st_reg <= vdo_pkg::ST_IDLE;
			endcase
		end
	end

	// Open-drain data pin: only ever pulls low, enable active low.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sda_o_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end
		else
		begin
			sda_o_reg <= 1'b0;
			sda_oe_n_reg <= ~((st_reg == vdo_pkg::ST_ADDR_ACK) || (st_reg == vdo_pkg::ST_SUB_ACK) ||
				(st_reg == vdo_pkg::ST_WACK) || (st_reg == vdo_pkg::ST_RDATA && !tx_reg[7]));
		end
	end

	// --------------------------------------------------------------
	// Writable configuration registers
	// --------------------------------------------------------------
	// Reserved bits are stored as written, except in the mux control register, which keeps only bit 7; the host keeps them at default.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			neg_mux_reg <= `VDO_RST_NEG_MUX;
			hs_src_reg <= `VDO_RST_HS_SRC;
			fld_src_reg <= `VDO_RST_FLD_SRC;
			pix_clk_cfg_reg <= `VDO_RST_PIX_CFG;
			crc_en_reg <= `VDO_RST_CRC_EN;
			mux_ctl_reg <= `VDO_RST_MUX_CTL;
		end
		else if (wr_stb)
		begin
			case (sub_reg)
				`VDO_OFS_NEG_MUX: neg_mux_reg <= shift_reg;
				`VDO_OFS_HS_SRC: hs_src_reg <= shift_reg;
				`VDO_OFS_FLD_SRC: fld_src_reg <= shift_reg;
				`VDO_OFS_PIX_CFG: pix_clk_cfg_reg <= shift_reg;
				`VDO_OFS_CRC_EN: crc_en_reg <= shift_reg;
				`VDO_OFS_MUX_CTL: mux_ctl_reg <= {shift_reg[7], 7'h00};
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Input mux, sync pins and pixel clock pin
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			manual_mux_enable_reg <= 1'b0;
			analog_input_n_reg <= 4'h0;
		end
		else
		begin
			manual_mux_enable_reg <= mux_ctl_reg[`VDO_BIT_MAN_MUX];
			if (mux_ctl_reg[`VDO_BIT_MAN_MUX] && neg_mux_reg[3:0] <= `VDO_NEG_MUX_MAX)
				analog_input_n_reg <= neg_mux_reg[3:0];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hsync_pin_reg <= 1'b0;
			field_pin_reg <= 1'b0;
			line_locked_pixel_clock_reg <= 1'b0;
		end
		else
		begin
			hsync_pin_reg <= pick_src(hs_src_reg[2:0], sync_in);
			field_pin_reg <= pick_src(fld_src_reg[2:0], sync_in);
			// Codes other than half rate fall back to full rate.
			line_locked_pixel_clock_reg <= (pix_clk_cfg_reg[6:4] == `VDO_PIX_HALF) ?
				pix_clk_half : pix_clk_full;
		end
	end

	// --------------------------------------------------------------
	// Captions, letterbox counts and copy-management check
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cap1_reg <= 8'h00;
			cap2_reg <= 8'h00;
		end
		else if (caption_in.valid)
		begin
			cap1_reg <= caption_in.byte_first;
			cap2_reg <= caption_in.byte_second;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			top_run_reg <= 8'h00;
			mid_run_reg <= 8'h00;
			bot_run_reg <= 8'h00;
			top_open_reg <= 1'b0;
		end
		else if (lbox_in.field_start)
		begin
			top_run_reg <= 8'h00;
			mid_run_reg <= 8'h00;
			bot_run_reg <= 8'h00;
			top_open_reg <= 1'b1;
		end
		else if (lbox_in.line_done)
		begin
			top_open_reg <= top_open_reg & lbox_in.line_black;
			if (top_open_reg && lbox_in.line_black)
				top_run_reg <= sat_inc(top_run_reg);
			if (lbox_in.in_middle && lbox_in.line_black)
				mid_run_reg <= sat_inc(mid_run_reg);
			bot_run_reg <= lbox_in.line_black ? sat_inc(bot_run_reg) : 8'h00;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lb_top_reg <= 8'h00;
			lb_mid_reg <= 8'h00;
			lb_bot_reg <= 8'h00;
		end
		else if (lbox_in.field_end)
		begin
			lb_top_reg <= top_run_reg;
			lb_mid_reg <= lbox_in.subtitles ? mid_run_reg : 8'h00;
			lb_bot_reg <= bot_run_reg;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cm_valid_reg <= 1'b0;
		else
			cm_valid_reg <= cm_rx_valid &
				(~crc_en_reg[`VDO_BIT_CRC_EN] | cm_crc_ok);
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	mux_route_a: assert property (@(posedge clk) disable iff (rst)
		mux_ctl_reg[7] && neg_mux_reg[3:0] <= 4'h8 |=> analog_input_n_reg == $past(neg_mux_reg[3:0]))
		else $error("negative input select not routed");
	mux_hold_a: assert property (@(posedge clk) disable iff (rst)
		!mux_ctl_reg[7] |=> !manual_mux_enable_reg && $stable(analog_input_n_reg))
		else $error("input select changed while manual mux off");
	hs_de_a: assert property (@(posedge clk) disable iff (rst)
		hs_src_reg[2:0] == 3'b011 |=> hsync_pin_reg == $past(sync_in.de))
		else $error("hsync pin not carrying data enable");
	fld_hs_a: assert property (@(posedge clk) disable iff (rst)
		fld_src_reg[2:0] == 3'b000 |=> field_pin_reg == $past(sync_in.hsync))
		else $error("field pin not carrying hsync");
	pix_rate_a: assert property (@(posedge clk) disable iff (rst)
		pix_clk_cfg_reg[6:4] == 3'b101 |=> line_locked_pixel_clock_reg == $past(pix_clk_half))
		else $error("pixel clock pin not at half rate");
	caption_hold_a: assert property (@(posedge clk) disable iff (rst)
		caption_in.valid ##1 !caption_in.valid [*2] |-> cap1_reg == $past(caption_in.byte_first, 2))
		else $error("caption byte not held");
	lb_top_a: assert property (@(posedge clk) disable iff (rst)
		lbox_in.field_start ##1 (lbox_in.line_done && lbox_in.line_black && !lbox_in.field_start)
		##1 lbox_in.field_end && !lbox_in.field_start |=> lb_top_reg == 8'h01)
		else $error("top black line count wrong");
	crc_gate_a: assert property (@(posedge clk) disable iff (rst)
		crc_en_reg[2] && !cm_crc_ok |=> !cm_valid_reg)
		else $error("copy-management valid without good checksum");
endmodule

/* tb/vdo_host_model.sv */
// Purpose: Host controller model on the two-wire serial control port.
// Assumes: Open-drain lines with pull-ups, resolved by the bench.
// Notes: Every clock phase lasts at least three cycles; only single-byte reads.
`timescale 1ns/1ps
module vdo_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_rel
);
	initial
	begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic line(input logic s, input logic d, input int n);
		@(posedge clk);
		scl <= s;
		sda_rel <= d;
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		line(1'b0, 1'b1, 2);
		line(1'b1, 1'b1, 3);
		line(1'b1, 1'b0, 3);
		line(1'b0, 1'b0, 2);
	endtask
	task automatic stop();
		line(1'b0, 1'b0, 2);
		line(1'b1, 1'b0, 3);
		line(1'b1, 1'b1, 3);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			line(1'b0, b[i], 2);
			line(1'b1, b[i], 3);
		end
		line(1'b0, 1'b1, 2);
		line(1'b1, 1'b1, 1);
		#1 ack = !sda_line;
		line(1'b1, 1'b1, 1);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
		output logic ok);
		logic a0, a1, a2;
		start();
		send({a, 1'b0}, a0);
		send(sub, a1);
		send(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d);
		logic ack;
		start();
		send({a, 1'b0}, ack);
		send(sub, ack);
		start();
		send({a, 1'b1}, ack);
		for (int i = 7; i >= 0; i--)
		begin
			line(1'b0, 1'b1, 2);
			line(1'b1, 1'b1, 1);
			#1 d[i] = sda_line;
			line(1'b1, 1'b1, 1);
		end
		line(1'b0, 1'b1, 2);
		line(1'b1, 1'b1, 3);
		stop();
	endtask
endmodule

/* tb/vdo_output_status_tb.sv */
// Purpose: Self-checking bench for the decoder output and status registers.
// Assumes: Host model drives the serial port; bench drives all video-side inputs.
// Notes: A cycle ceiling cuts a hang short.
`timescale 1ns/1ps
module vdo_output_status_tb;
	localparam logic [6:0] DEV = 7'h20;
	logic clk, rst, scl, sda_rel, sda_o, sda_oe_n, pix_full, pix_half, rx_valid, crc_ok;
	logic man_en, hs_pin, fld_pin, pix_pin, cm_valid;
	logic [3:0] ain;
	wire logic sda_line;
	vdo_pkg::vdo_sync_t sync_in;
	vdo_pkg::vdo_caption_t cap;
	vdo_pkg::vdo_lbox_t lbox;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycle_cnt = 0;
	assign sda_line = sda_rel & (sda_oe_n | sda_o);
	vdo_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
	vdo_output_status #(.DEV_ADDR(DEV)) dut (.clk(clk), .rst(rst), .scl_i(scl),
		.sda_i(sda_line), .sda_o_reg(sda_o), .sda_oe_n_reg(sda_oe_n), .sync_in(sync_in),
		.pix_clk_full(pix_full), .pix_clk_half(pix_half), .caption_in(cap),
		.lbox_in(lbox), .cm_rx_valid(rx_valid), .cm_crc_ok(crc_ok),
		.manual_mux_enable_reg(man_en), .analog_input_n_reg(ain),
		.hsync_pin_reg(hs_pin), .field_pin_reg(fld_pin),
		.line_locked_pixel_clock_reg(pix_pin), .cm_valid_reg(cm_valid));
	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycle_cnt++;
		if (cycle_cnt == 40000)
		begin
			error_cnt++;
			$display("mismatch at %0t: run did not finish", $time);
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checked %0d, mismatched %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		logic ok;
		host.wr(DEV, sub, d, ok);
		check({7'h0, ok}, 8'h01);
	endtask
	task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(DEV, sub, v);
		check(v, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_reset();
		logic ok;
		rd_chk(8'h60, 8'h10);
		rd_chk(8'h6A, 8'h00);
		rd_chk(8'h6B, 8'h10);
		rd_chk(8'h8F, 8'h00);
		rd_chk(8'hB2, 8'h00);
		rd_chk(8'hC4, 8'h00);
		for (int a = 8'h99; a <= 8'h9D; a++)
			rd_chk(8'(a), 8'h00);
		rd_chk(8'h70, 8'h00);
		host.wr(7'h21, 8'h60, 8'h18, ok);
		check({7'h0, ok}, 8'h00);
		$display("reset test done");
	endtask
	task automatic test_mux();
		wr(8'h60, 8'h13);
		check({7'h0, man_en}, 8'h00);
		check({4'h0, ain}, 8'h00);
		wr(8'hC4, 8'h80);
		check({7'h0, man_en}, 8'h01);
		check({4'h0, ain}, 8'h03);
		wr(8'h60, 8'h19);
		check({4'h0, ain}, 8'h03);
		wr(8'h60, 8'h18);
		check({4'h0, ain}, 8'h08);
		wr(8'hC4, 8'h00);
		wr(8'h60, 8'h10);
		check({4'h0, ain}, 8'h08);
		rd_chk(8'h60, 8'h10);
		$display("mux test done");
	endtask
	task automatic test_sync();
		int j;
		for (int k = 0; k < 5; k++)
		begin
			j = (k + 2) % 5;
			wr(8'h6A, 8'(k));
			wr(8'h6B, 8'(8'h10 | j));
			@(posedge clk) sync_in <= 5'(5'h10 >> k);
			settle(2);
			check({6'h0, hs_pin, fld_pin}, 8'h02);
			@(posedge clk) sync_in <= 5'(5'h10 >> j);
			settle(2);
			check({6'h0, hs_pin, fld_pin}, 8'h01);
		end
		$display("sync test done");
	endtask
	task automatic clk_chk(input logic half);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clk);
			pix_full <= c[1];
			pix_half <= c[0];
			settle(2);
			check({7'h0, pix_pin}, {7'h0, half ? c[0] : c[1]});
		end
	endtask
	task automatic test_clock();
		clk_chk(1'b0);
		wr(8'h8F, 8'h50);
		clk_chk(1'b1);
		wr(8'h8F, 8'h00);
		clk_chk(1'b0);
		$display("pixel clock test done");
	endtask
	task automatic test_caption();
		@(posedge clk) cap <= {1'b1, 8'h95, 8'h2A};
		@(posedge clk) cap <= 17'h0_0000;
		rd_chk(8'h99, 8'h95);
		rd_chk(8'h9A, 8'h2A);
		wr(8'h99, 8'hFF);
		rd_chk(8'h99, 8'h95);
		$display("caption test done");
	endtask
	task automatic lb(input logic [2:0] ev, input logic blk, input logic mid, input int n);
		repeat (n)
		begin
			@(posedge clk) lbox <= {ev, blk, mid, 1'b1};
			@(posedge clk) lbox <= {3'h0, blk, mid, 1'b1};
		end
	endtask
	task automatic test_lbox();
		for (int s = 1; s >= 0; s--)
		begin
			lb(3'h4, 1'b0, 1'b0, 1);
			lb(3'h1, 1'b1, 1'b0, 3);
			lb(3'h1, 1'b0, 1'b0, 1);
			lb(3'h1, 1'b1, 1'b1, 2);
			lb(3'h1, 1'b0, 1'b0, 1);
			lb(3'h1, 1'b1, 1'b0, 4);
			@(posedge clk) lbox <= {3'h2, 2'h0, 1'(s)};
			@(posedge clk) lbox <= 6'h00;
			rd_chk(8'h9B, 8'h03);
			rd_chk(8'h9C, s ? 8'h02 : 8'h00);
			rd_chk(8'h9D, 8'h04);
		end
		// A field with one black line straight after its start and nothing after it.
		@(posedge clk) lbox <= 6'h20;
		@(posedge clk) lbox <= 6'h0C;
		@(posedge clk) lbox <= 6'h10;
		@(posedge clk) lbox <= 6'h00;
		rd_chk(8'h9B, 8'h01);
		$display("letterbox test done");
	endtask
	task automatic crc(input logic ok, input logic exp);
		@(posedge clk);
		rx_valid <= 1'b1;
		crc_ok <= ok;
		@(posedge clk) rx_valid <= 1'b0;
		#1 check({7'h0, cm_valid}, {7'h0, exp});
		settle(1);
		check({7'h0, cm_valid}, 8'h00);
	endtask
	task automatic test_crc();
		crc(1'b0, 1'b1);
		wr(8'hB2, 8'h1C);
		crc(1'b0, 1'b0);
		crc(1'b1, 1'b1);
		rd_chk(8'hB2, 8'h00);
		wr(8'hB2, 8'h18);
		crc(1'b0, 1'b1);
		$display("checksum test done");
	endtask
	initial
	begin
		rst = 1'b1;
		sync_in = 5'h00;
		pix_full = 1'b0;
		pix_half = 1'b0;
		cap = 17'h0_0000;
		lbox = 6'h00;
		rx_valid = 1'b0;
		crc_ok = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_mux();
		test_sync();
		test_clock();
		test_caption();
		test_lbox();
		test_crc();
		print_verdict();
	end
endmodule
